// file: core/sct_ctl.sv
/*
 * Memory controller end of the link: single-word user requests become
 * activate, column, precharge, refresh and self-refresh commands.
 * Assumes the SDRAM end on the same clock; user holds a request until ack.
 */
// Notes on behaviour
// (R1) Activate to column waits the row delay
// (R2) Precharge to activate waits recovery time
// (R3) Row open between least and longest time
// (R4) Same-bank activates spaced by row cycle
// (R5) Different-bank activates spaced apart
// (R6) Column commands may follow every clock
// (R7) Two clocks after mode programming
// (R8) 4096 refreshes within each 64 ms
// (R9) One clock after leaving self refresh
// (R10) Read mask stops output two clocks later
// (R11) Write mask blocks data same clock
// (R12) Two clocks from write data to precharge
// (R13) Nanosecond limits rounded up to clocks; the longest row-open time is rounded down
// (R14) Per-bank counters plus shared activate counter
// (R15) Cycle counts set at build time
`timescale 1ns/1ps
`default_nettype none
module sct_ctl
    import sct_pkg::*;
#(
    parameter int SPEED_GRADE        = 0,
    parameter int REFRESH_PERIOD_CYC = REFRESH_PERIOD_CYC_DEF
)(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    // Request
    input  wire logic              req_valid_i,
    input  wire logic              req_write_i,
    input  wire logic [BANK_W-1:0] req_bank_i,
    input  wire logic [ROW_W-1:0]  req_row_i,
    input  wire logic [COL_W-1:0]  req_col_i,
    input  wire logic [DATA_W-1:0] req_wdata_i,
    input  wire logic              req_wmask_i,
    output logic                   req_ack_o,
    // Read answer
    output logic                   rsp_valid_o,
    output logic [DATA_W-1:0]      rsp_rdata_o,
    // Power control and status
    input  wire logic              sref_req_i,
    output logic                   sref_active_o,
    output logic                   init_done_o,
    // Link
    sct_link_if.ctl                link
);
    // (R13) (R15) cycle counts from grade and clock
    localparam sct_cnt_t RCD_CYC  = sct_cyc_up(ACTIVATE_TO_COLUMN_DELAY_NS[SPEED_GRADE]);
    localparam sct_cnt_t RP_CYC   = sct_cyc_up(PRECHARGE_RECOVERY_TIME_NS[SPEED_GRADE]);
    localparam sct_cnt_t RAS_CYC  = sct_cyc_up(ROW_OPEN_TIME_NS[SPEED_GRADE]);
    localparam sct_cnt_t RASX_CYC = sct_cyc_down(ROW_OPEN_TIME_MAX_NS);
    localparam sct_cnt_t RC_CYC   = sct_cyc_up(ROW_CYCLE_TIME_NS[SPEED_GRADE]);
    localparam sct_cnt_t RRD_CYC  = sct_cyc_up(CROSS_BANK_ACTIVATE_PERIOD_NS[SPEED_GRADE]);
    localparam sct_cnt_t WR_CYC   = sct_cnt_t'(WRITE_RECOVERY_CYC);
    localparam int       REF_GAP  = REFRESH_PERIOD_CYC / REFRESH_ROWS;
    localparam sct_cnt_t ONE      = sct_cnt_t'(1);
    typedef enum logic [1:0] {ST_INIT, ST_RUN, ST_SREF} sct_state_e;
    sct_state_e state_q, state_d;
    logic [NUM_BANKS-1:0] open_q;
    logic [ROW_W-1:0]     row_q [NUM_BANKS];
    sct_cnt_t rcd_q [NUM_BANKS], rp_q [NUM_BANKS], ras_q [NUM_BANKS];
    sct_cnt_t rc_q  [NUM_BANKS], wr_q [NUM_BANKS], age_q [NUM_BANKS];
    sct_cnt_t rrd_q, gap_q;
    logic [31:0] ref_cnt_q;
    logic        ref_pend_q;
    logic [CAS_LATENCY-1:0] rd_sh_q;
    sct_cmd_e          cmd_d;
    logic [BANK_W-1:0] bank_d;
    logic [ROW_W-1:0]  addr_d;
    logic              cke_d, take_d, close_all, all_closed, all_idle;
    // Bank may be precharged: open, row time met, write recovered
    function automatic logic can_pre(input logic op, input sct_cnt_t ras, input sct_cnt_t wr);
        return op && ras == '0 && wr == '0;
    endfunction
    assign close_all = ref_pend_q || sref_req_i;
    // ==========================================================
    // Command choice
    always_comb begin
        logic done;
        done       = 1'b0;
        cmd_d      = SCT_NOP;
        bank_d     = '0;
        addr_d     = '0;
        cke_d      = link.cke;
        take_d     = 1'b0;
        state_d    = state_q;
        all_closed = (open_q == '0);
        all_idle   = 1'b1;
        for (int b = 0; b < NUM_BANKS; b++) begin
            all_idle = all_idle && rp_q[b] == '0 && rc_q[b] == '0;
        end
        unique case (state_q)
            ST_INIT: begin
                cmd_d   = SCT_MRS;
                addr_d  = MODE_RESET;
                cke_d   = 1'b1;
                state_d = ST_RUN;
            end
            ST_SREF: begin
                if (!sref_req_i) begin
                    cmd_d   = SCT_SRX;
                    cke_d   = 1'b1;
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                // (R7) (R9) settle gap holds every command
                if (gap_q == '0) begin
                    // (R3) close rows for refresh or self refresh, or at half the age limit
                    for (int b = 0; b < NUM_BANKS; b++) begin
                        if (!done && can_pre(open_q[b], ras_q[b], wr_q[b])
                            && (close_all || age_q[b] >= (RASX_CYC >> 1))) begin
                            done   = 1'b1;
                            cmd_d  = SCT_PRE;
                            bank_d = BANK_W'(b);
                        end
                    end
                    if (!done && close_all) begin
                        // (R8) refresh once banks are idle
                        if (all_closed && all_idle) begin
                            if (ref_pend_q) begin
                                cmd_d = SCT_REF;
                            end else begin
                                cmd_d   = SCT_SRE;
                                cke_d   = 1'b0;
                                state_d = ST_SREF;
                            end
                        end
                    end else if (!done && req_valid_i && !req_ack_o) begin
                        bank_d = req_bank_i;
                        if (open_q[req_bank_i] && row_q[req_bank_i] == req_row_i) begin
                            // (R1) column after row delay
                            if (rcd_q[req_bank_i] == '0) begin
                                cmd_d  = req_write_i ? SCT_WR : SCT_RD;
                                addr_d = ROW_W'(req_col_i);
                                take_d = 1'b1;
                            end
                        end else if (open_q[req_bank_i]) begin
                            // (R12) precharge only after recovery
                            if (can_pre(1'b1, ras_q[req_bank_i], wr_q[req_bank_i]))
                                cmd_d = SCT_PRE;
                        end else if (rp_q[req_bank_i] == '0 && rc_q[req_bank_i] == '0
                                     && rrd_q == '0) begin
                            // (R2) (R4) (R5) activate spacing
                            cmd_d  = SCT_ACT;
                            addr_d = req_row_i;
                        end
                    end
                end
            end
        endcase
    end
    // ==========================================================
    // Link outputs, all registered
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            link.cke       <= 1'b1;
            link.cmd       <= SCT_NOP;
            link.bank      <= '0;
            link.addr      <= '0;
            link.dqm       <= 1'b0;
            link.dq_ctl_o  <= '0;
            link.dq_ctl_oe <= 1'b0;
        end else begin
            link.cke       <= cke_d;
            link.cmd       <= cmd_d;
            link.bank      <= bank_d;
            link.addr      <= addr_d;
            // (R11) mask rides with its write data
            link.dqm       <= take_d && req_write_i && req_wmask_i;
            link.dq_ctl_o  <= req_wdata_i;
            link.dq_ctl_oe <= take_d && req_write_i;
        end
    end
    // State, acknowledge and status flags
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q       <= ST_INIT;
            req_ack_o     <= 1'b0;
            sref_active_o <= 1'b0;
            init_done_o   <= 1'b0;
        end else begin
            state_q       <= state_d;
            req_ack_o     <= take_d;
            sref_active_o <= (state_d == ST_SREF);
            init_done_o   <= init_done_o || (state_q == ST_INIT);
        end
    end
    // ==========================================================
    // (R14) per-bank timing counters
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            open_q <= '0;
            row_q  <= '{default: '0};
            rcd_q  <= '{default: '0};
            rp_q   <= '{default: '0};
            ras_q  <= '{default: '0};
            rc_q   <= '{default: '0};
            wr_q   <= '{default: '0};
            age_q  <= '{default: '0};
        end else begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                rcd_q[b] <= sct_dec(rcd_q[b]);
                rp_q[b]  <= sct_dec(rp_q[b]);
                ras_q[b] <= sct_dec(ras_q[b]);
                rc_q[b]  <= sct_dec(rc_q[b]);
                wr_q[b]  <= sct_dec(wr_q[b]);
                age_q[b] <= open_q[b] ? age_q[b] + ONE : '0;
                if (cmd_d == SCT_REF)
                    rc_q[b] <= RC_CYC - ONE;
            end
            if (cmd_d == SCT_ACT) begin
                open_q[bank_d] <= 1'b1;
                row_q[bank_d]  <= addr_d;
                rcd_q[bank_d]  <= RCD_CYC - ONE;
                ras_q[bank_d]  <= RAS_CYC - ONE;
                rc_q[bank_d]   <= RC_CYC - ONE;
            end
            if (cmd_d == SCT_PRE) begin
                open_q[bank_d] <= 1'b0;
                rp_q[bank_d]   <= RP_CYC - ONE;
            end
            // (R12) write data to precharge gap
            if (cmd_d == SCT_WR)
                wr_q[bank_d] <= WR_CYC;
        end
    end
    // (R5) shared activate spacing and (R7) (R9) settle gap
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rrd_q <= '0;
            gap_q <= '0;
        end else begin
            rrd_q <= (cmd_d == SCT_ACT) ? RRD_CYC - ONE : sct_dec(rrd_q);
            gap_q <= (cmd_d == SCT_MRS) ? sct_cnt_t'(MODE_PROGRAM_SETTLE_CYC - 1)
                   : (cmd_d == SCT_SRX) ? sct_cnt_t'(SELF_REFRESH_LEAVE_DELAY_CYC - 1)
                   : sct_dec(gap_q);
        end
    end
    // ==========================================================
    // (R8) refresh pacing, a new request wins over the clear
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ref_cnt_q  <= 32'(REF_GAP - 1);
            ref_pend_q <= 1'b0;
        end else begin
            ref_cnt_q  <= (ref_cnt_q == '0) ? 32'(REF_GAP - 1) : ref_cnt_q - 32'd1;
            ref_pend_q <= (ref_cnt_q == '0) || (ref_pend_q && cmd_d != SCT_REF);
        end
    end
    // ==========================================================
    // Read answer captured a CAS latency after the command
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_sh_q     <= '0;
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= '0;
        end else begin
            rd_sh_q     <= {rd_sh_q[CAS_LATENCY-2:0], (link.cmd == SCT_RD)};
            rsp_valid_o <= rd_sh_q[CAS_LATENCY-1];
            if (rd_sh_q[CAS_LATENCY-1])
                rsp_rdata_o <= link.dq;
        end
    end
endmodule
`default_nettype wire

// file: core/sct_pkg.sv
/*
 * Shared constants and types for the SDRAM command-timing pair:
 * link geometry, command set, timing figures per speed grade and the
 * conversion of nanosecond limits into clock counts.
 * Assumes a single clock of CLK_PERIOD_NS on both ends.
 */
`default_nettype none
package sct_pkg;
    // ==========================================================
    // Geometry and clock
    localparam int CLK_PERIOD_NS  = 50;
    localparam int NUM_BANKS      = 4;
    localparam int BANK_W         = 2;
    localparam int ROW_W          = 12;
    localparam int COL_W          = 4;
    localparam int DATA_W         = 8;
    localparam int CNT_W          = 16;
    localparam int CAS_LATENCY    = 2;
    localparam int GRADE_COUNT    = 3;

    // ==========================================================
    // Timing figures, index is the speed grade (fastest first)
    localparam int ACTIVATE_TO_COLUMN_DELAY_NS[GRADE_COUNT]   = '{15, 20, 20};
    localparam int PRECHARGE_RECOVERY_TIME_NS[GRADE_COUNT]    = '{15, 20, 20};
    localparam int ROW_OPEN_TIME_NS[GRADE_COUNT]              = '{42, 45, 48};
    localparam int ROW_OPEN_TIME_MAX_NS                       = 100000;
    localparam int ROW_CYCLE_TIME_NS[GRADE_COUNT]             = '{60, 67, 70};
    localparam int CROSS_BANK_ACTIVATE_PERIOD_NS[GRADE_COUNT] = '{14, 15, 16};
    localparam int COLUMN_COMMAND_PERIOD_CYC                  = 1;
    localparam int MODE_PROGRAM_SETTLE_CYC                    = 2;
    localparam int REFRESH_INTERVAL_MS                        = 64;
    localparam int REFRESH_ROWS                               = 4096;
    localparam int SELF_REFRESH_LEAVE_DELAY_CYC               = 1;
    localparam int READ_MASK_DISABLE_LATENCY_CYC              = 2;
    localparam int WRITE_MASK_LATENCY_CYC                     = 0;
    localparam int WRITE_RECOVERY_CYC                         = 2;
    localparam int NS_PER_MS                                  = 1000000;
    localparam int REFRESH_PERIOD_CYC_DEF = REFRESH_INTERVAL_MS * (NS_PER_MS / CLK_PERIOD_NS);

    // Mode word programmed at start-up (burst of one, latency two)
    localparam logic [ROW_W-1:0] MODE_RESET = 12'h020;

    // ==========================================================
    // Command set on the link
    typedef enum logic [3:0] {
        SCT_NOP, SCT_ACT, SCT_RD, SCT_WR, SCT_PRE,
        SCT_MRS, SCT_REF, SCT_SRE, SCT_SRX
    } sct_cmd_e;

    typedef logic [CNT_W-1:0] sct_cnt_t;

    // Least time: round fractional cycles up, never under one
    function automatic sct_cnt_t sct_cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? sct_cnt_t'(1) : sct_cnt_t'(c);
    endfunction

    // Longest time: round down, never under one
    function automatic sct_cnt_t sct_cyc_down(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? sct_cnt_t'(1) : sct_cnt_t'(c);
    endfunction

    // Saturating down count
    function automatic sct_cnt_t sct_dec(input sct_cnt_t c);
        return (c == '0) ? c : c - sct_cnt_t'(1);
    endfunction
endpackage
`default_nettype wire

// file: core/sct_link_if.sv
/*
 * Link between the memory controller and the SDRAM end.
 * Assumes both ends run on the clock passed in; the data wire is
 * resolved here from the two output enables.
 */
`timescale 1ns/1ps
`default_nettype none
interface sct_link_if
    import sct_pkg::*;
(
    input wire logic clk
);
    logic                 cke;
    sct_cmd_e             cmd;
    logic [BANK_W-1:0]    bank;
    logic [ROW_W-1:0]     addr;
    logic                 dqm;
    logic [DATA_W-1:0]    dq_ctl_o;
    logic                 dq_ctl_oe;
    logic [DATA_W-1:0]    dq_mem_o;
    logic                 dq_mem_oe;
    wire  [DATA_W-1:0]    dq;

    // Shared data wire level
    assign dq = dq_ctl_oe ? dq_ctl_o : (dq_mem_oe ? dq_mem_o : '0);

    modport ctl (output cke, cmd, bank, addr, dqm, dq_ctl_o, dq_ctl_oe, input dq, clk);
    modport mem (input cke, cmd, bank, addr, dqm, dq, clk, output dq_mem_o, dq_mem_oe);
endinterface
`default_nettype wire

// file: core/sct_mem.sv
/*
 * SDRAM end of the link: four banks of small flop storage, read
 * pipeline with mask-driven output disable, masked writes and the
 * internal write-recovery interlock before precharge.
 * Assumes the controller keeps the command spacing; burst length one.
 */
`timescale 1ns/1ps
`default_nettype none
module sct_mem
    import sct_pkg::*;
(
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          arst_n_i,
    // Link
    sct_link_if.mem            link,
    // Status
    output logic [NUM_BANKS-1:0] bank_open_o,
    output logic [ROW_W-1:0]     mode_o,
    output logic                 sref_o,
    output logic                 cmd_err_o
);
    localparam int DEPTH = NUM_BANKS << COL_W;
    localparam int IDX_W = BANK_W + COL_W;
    localparam int RML   = READ_MASK_DISABLE_LATENCY_CYC;
    localparam int RSW   = CAS_LATENCY - 1;
    localparam int DMW   = RML - 1;

    logic [DATA_W-1:0]    mem_q [DEPTH];
    logic [NUM_BANKS-1:0] pre_pend_q;
    sct_cnt_t             wr_q [NUM_BANKS];
    logic [CAS_LATENCY-2:0] rd_sh_q;
    logic [IDX_W-1:0]     rd_idx_q [CAS_LATENCY-1];
    logic [RML-2:0]       dqm_dl_q;
    logic [IDX_W-1:0]     idx;
    logic                 live;
    logic                 col_cmd;

    // Commands other than self-refresh entry count only while the clock is enabled
    assign live    = link.cke && !sref_o;
    assign idx     = {link.bank, link.addr[COL_W-1:0]};
    assign col_cmd = live && (link.cmd == SCT_RD || link.cmd == SCT_WR);

    // ==========================================================
    // Mode word and self refresh
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_o <= MODE_RESET;
            sref_o <= 1'b0;
        end else begin
            if (live && link.cmd == SCT_MRS) begin
                mode_o <= link.addr;
            end
            if (!sref_o && link.cmd == SCT_SRE && !link.cke) begin
                sref_o <= 1'b1;
            end else if (link.cke && link.cmd == SCT_SRX) begin
                sref_o <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Bank state with write-recovery interlock
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bank_open_o <= '0;
            pre_pend_q  <= '0;
            for (int b = 0; b < NUM_BANKS; b++) begin
                wr_q[b] <= '0;
            end
        end else begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                wr_q[b] <= sct_dec(wr_q[b]);
                // (R12) deferred precharge
                if (pre_pend_q[b] && wr_q[b] == '0) begin
                    bank_open_o[b] <= 1'b0;
                    pre_pend_q[b]  <= 1'b0;
                end
            end
            if (live && link.cmd == SCT_ACT) begin
                bank_open_o[link.bank] <= 1'b1;
            end
            // (R12) recovery after write data
            if (live && link.cmd == SCT_WR) begin
                wr_q[link.bank] <= sct_cnt_t'(WRITE_RECOVERY_CYC - 1);
            end
            if (live && link.cmd == SCT_PRE) begin
                if (wr_q[link.bank] != '0) begin
                    pre_pend_q[link.bank] <= 1'b1;
                end else begin
                    bank_open_o[link.bank] <= 1'b0;
                end
            end
        end
    end

    // Column command to closed bank, or activate to open bank
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cmd_err_o <= 1'b0;
        end else begin
            cmd_err_o <= (col_cmd && !bank_open_o[link.bank])
                      || (live && link.cmd == SCT_ACT && bank_open_o[link.bank]);
        end
    end

    // ==========================================================
    // (R11) write mask blocks data on its own clock
    always_ff @(posedge clk_i) begin
        if (live && link.cmd == SCT_WR && !link.dqm) begin
            mem_q[idx] <= link.dq;
        end
    end

    // ==========================================================
    // (R6) read accepted on every clock
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_sh_q  <= '0;
            dqm_dl_q <= '0;
            for (int s = 0; s < CAS_LATENCY - 1; s++) begin
                rd_idx_q[s] <= '0;
            end
        end else begin
            rd_sh_q     <= RSW'({rd_sh_q, (live && link.cmd == SCT_RD)});
            rd_idx_q[0] <= idx;
            for (int s = 1; s < CAS_LATENCY - 1; s++) begin
                rd_idx_q[s] <= rd_idx_q[s-1];
            end
            dqm_dl_q <= DMW'({dqm_dl_q, link.dqm});
        end
    end

    // (R10) masked read drops drive two clocks on
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            link.dq_mem_o  <= '0;
            link.dq_mem_oe <= 1'b0;
        end else begin
            link.dq_mem_o  <= mem_q[rd_idx_q[CAS_LATENCY-2]];
            link.dq_mem_oe <= rd_sh_q[CAS_LATENCY-2] && !dqm_dl_q[RML-2];
        end
    end
endmodule
`default_nettype wire

// file: dv/sct_chk.sv
/* Link checks for the controller and SDRAM ends.
   Assumes one clock and the pair's asynchronous low reset. */
`timescale 1ns/1ps
`default_nettype none
module sct_chk
    import sct_pkg::*;
(
    // Clock, reset and link signals
    input  wire logic              clk,
    input  wire logic              arst_n_i,
    input  wire logic              cke,
    input  var  sct_cmd_e          cmd,
    input  wire logic [BANK_W-1:0] bank,
    input  wire logic              dqm,
    input  wire logic              dq_ctl_oe,
    input  wire logic              dq_mem_oe
);
    // ==========================================================
    // Command spacing and data timing
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n_i);
    property p_rc;
        cmd == SCT_ACT |=> !(cmd == SCT_ACT && bank == $past(bank));
    endproperty
    a_rc: assert property (p_rc) else $error("Same bank activates too close");
    property p_mrs;
        cmd == SCT_MRS |=> cmd == SCT_NOP;
    endproperty
    a_mrs: assert property (p_mrs) else $error("Command too soon after mode set");
    property p_srx;
        cmd == SCT_SRX |-> cke && !$past(cke);
    endproperty
    a_srx: assert property (p_srx) else $error("Self refresh leave out of place");
    property p_sre;
        cmd == SCT_SRE |-> !cke;
    endproperty
    a_sre: assert property (p_sre) else $error("Self refresh entry with clock enable");
    property p_rdmask;
        $past(dqm, 2) |-> !dq_mem_oe;
    endproperty
    a_rdmask: assert property (p_rdmask) else $error("Masked data still driven");
    property p_rdlat;
        cmd == SCT_RD |-> ##2 dq_mem_oe;
    endproperty
    a_rdlat: assert property (p_rdlat) else $error("Read data missing");
    property p_wrdata;
        cmd == SCT_WR |-> dq_ctl_oe && !dq_mem_oe;
    endproperty
    a_wrdata: assert property (p_wrdata) else $error("Write data not with command");
    property p_wrrec;
        cmd == SCT_WR |=> !(cmd == SCT_PRE && bank == $past(bank))
            ##1 !(cmd == SCT_PRE && bank == $past(bank, 2));
    endproperty
    a_wrrec: assert property (p_wrrec) else $error("Precharge inside write recovery");
    // Main scenarios reached
    c_rd: cover property (cmd == SCT_RD);
    c_mwr: cover property (cmd == SCT_WR && dqm);
    c_sre: cover property (cmd == SCT_SRE);
endmodule
`default_nettype wire

// file: dv/test_sdram_command_timing.sv
/* Bench driving user requests into the controller end.
   Assumes both ends on one 20 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module test_sdram_command_timing
    import sct_pkg::*;
;
    typedef struct packed {
        logic w; logic [BANK_W-1:0] b; logic [ROW_W-1:0] r; logic [COL_W-1:0] c; logic [DATA_W-1:0] d; logic m;
    } sct_row_s;
    logic                 clk_i, arst_n_i, req_valid_i, req_write_i, req_wmask_i, sref_req_i;
    logic                 req_ack_o, rsp_valid_o, sref_active_o, init_done_o, sref_o, cmd_err_o;
    logic [BANK_W-1:0]    req_bank_i;
    logic [ROW_W-1:0]     req_row_i, mode_o;
    logic [COL_W-1:0]     req_col_i;
    logic [DATA_W-1:0]    req_wdata_i, rsp_rdata_o;
    logic [NUM_BANKS-1:0] bank_open_o;
    int                   failures = 0, tests_run = 0, ref_n = 0, err_n = 0;
    // Rows: write data, or expected read data
    sct_row_s rows[8] = '{'{1'h1, 2'h0, 12'h001, 4'h2, 8'ha5, 1'h0}, '{1'h1, 2'h1, 12'h002, 4'h3, 8'h3c, 1'h0},
        '{1'h0, 2'h0, 12'h001, 4'h2, 8'ha5, 1'h0}, '{1'h0, 2'h1, 12'h002, 4'h3, 8'h3c, 1'h0},
        '{1'h1, 2'h0, 12'h001, 4'h2, 8'hff, 1'h1}, '{1'h0, 2'h0, 12'h001, 4'h2, 8'ha5, 1'h0},
        '{1'h1, 2'h0, 12'h7ff, 4'hf, 8'h5a, 1'h0}, '{1'h0, 2'h0, 12'h7ff, 4'hf, 8'h5a, 1'h0}};

    // ==========================================================
    // Design, link and checker
    sct_link_if sct_link_if_inst (.clk(clk_i));
    sct_ctl #(.SPEED_GRADE(0), .REFRESH_PERIOD_CYC(40960)) sct_ctl_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_bank_i(req_bank_i), .req_row_i(req_row_i),
        .req_col_i(req_col_i), .req_wdata_i(req_wdata_i), .req_wmask_i(req_wmask_i), .req_ack_o(req_ack_o),
        .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .sref_req_i(sref_req_i),
        .sref_active_o(sref_active_o), .init_done_o(init_done_o), .link(sct_link_if_inst));
    sct_mem sct_mem_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .link(sct_link_if_inst),
        .bank_open_o(bank_open_o), .mode_o(mode_o), .sref_o(sref_o), .cmd_err_o(cmd_err_o));
    sct_chk chk_inst (.clk(clk_i), .arst_n_i(arst_n_i), .cke(sct_link_if_inst.cke), .cmd(sct_link_if_inst.cmd),
        .bank(sct_link_if_inst.bank), .dqm(sct_link_if_inst.dqm), .dq_ctl_oe(sct_link_if_inst.dq_ctl_oe),
        .dq_mem_oe(sct_link_if_inst.dq_mem_oe));

    // ==========================================================
    // Clock, monitor and tasks
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // Count refreshes and commands flagged by cmd_err_o
    always @(posedge clk_i) begin
        if (sct_link_if_inst.cmd == SCT_REF) ref_n++;
        if (cmd_err_o === 1'b1) err_n++;
    end
    task automatic wait_for(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 300) begin
            @(negedge clk_i);
            n++;
        end
        `CHK(s, v)
    endtask
    task automatic xfer(input sct_row_s x);
        @(negedge clk_i);
        {req_write_i, req_bank_i, req_row_i, req_col_i, req_wdata_i, req_wmask_i} = x;
        req_valid_i = 1'b1;
        wait_for(req_ack_o, 1'b1);
        req_valid_i = 1'b0;
        if (!x.w) begin
            wait_for(rsp_valid_o, 1'b1);
            `CHK(rsp_rdata_o, x.d)
        end
    endtask
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ==========================================================
    // Tests
    initial begin
        arst_n_i = 1'b0;
        {req_valid_i, req_write_i, req_wmask_i, sref_req_i, req_bank_i, req_row_i, req_col_i, req_wdata_i} = '0;
        repeat (12) @(negedge clk_i);
        `CHK(mode_o, 12'h020)
        `CHK(sct_link_if_inst.cmd, SCT_NOP)
        arst_n_i = 1'b1;
        wait_for(init_done_o, 1'b1);
        foreach (rows[i]) xfer(rows[i]);
        // Self refresh: banks closed, clock enable low, data kept
        sref_req_i = 1'b1;
        wait_for(sref_active_o, 1'b1);
        `CHK(sct_link_if_inst.cke, 1'b0)
        `CHK(bank_open_o, 4'h0)
        repeat (20) @(negedge clk_i);
        `CHK(sref_o, 1'b1)
        sref_req_i = 1'b0;
        wait_for(sref_active_o, 1'b0);
        xfer(rows[7]);
        `CHK(sref_o, 1'b0)
        `CHK(ref_n != 0, 1'b1)
        `CHK(err_n, 0)
        end_sim;
    end
    // Watchdog
    initial begin
        #2000000;
        failures++;
        end_sim;
    end
endmodule
`default_nettype wire
